/* File: spm_map.svh */
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// ****
// Power state field encodings
// ****
`define SPM_PS_D0 2'h0
`define SPM_PS_D3H 2'h3

// ****
// Timing
// ****
`define SPM_CLK_NS 10
`define SPM_TICK_NS 1000
`define SPM_TICK_CYC ((`SPM_TICK_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_TICK_W 7

// ****
// Power budgeting capability
// ****
`define SPM_PB_CAP_OFS 12'h200
`define SPM_PB_HDR_RST 32'h0000_0000
`define SPM_PB_DV_RST 32'h0000_0000
`define SPM_PB_DV_NUM 8
`define SPM_PB_IDX_W 3
`define SPM_CTX_KEPT_RST 1'h1

`endif

/* File: spm_pkg.sv */
package spm_pkg;

    // Device power states of one bridge port
    typedef enum logic [1:0] {
        SPM_D0U, SPM_D0A, SPM_D3H, SPM_D3C
    } spm_dstate_t;

    // Turn-off acknowledgement aggregation
    typedef enum logic [1:0] {
        SPM_AG_IDLE, SPM_AG_WAIT, SPM_AG_DONE
    } spm_agg_t;

    // Received packet classes
    typedef enum logic [2:0] {
        SPM_K_CFG0, SPM_K_MSG_SELF, SPM_K_CPL_SELF,
        SPM_K_CPL_THRU, SPM_K_REQ
    } spm_kind_t;

    // Packet dispositions
    typedef enum logic [2:0] {
        SPM_R_NONE, SPM_R_ACCEPT, SPM_R_FWD, SPM_R_UR,
        SPM_R_UC, SPM_R_HOLD, SPM_R_DROP
    } spm_disp_t;

    typedef struct packed {
        logic vld;
        logic sec;
        spm_kind_t kind;
        logic [1:0] src;
        logic [1:0] dst;
        logic rx_err;
    } spm_pkt_t;

    typedef struct packed {
        logic vld;
        spm_disp_t disp;
        logic err_msg;
    } spm_res_t;

endpackage

/* File: spm_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.svh"

module spm_port #(
    parameter int TW = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_cfg_done,
    input wire logic i_pm_wr,
    input wire logic [1:0] i_pm_wr_data,
    input wire logic i_power_removed,
    input wire logic i_hp_event,
    input wire logic i_wake_clr,
    input wire logic i_pme_allow,
    input wire logic [TW-1:0] i_wake_retry_timeout,
    input wire logic [TW-1:0] i_turnoff_ack_timeout,
    input wire logic i_turnoff_fwd,
    input wire logic i_ack_rx,
    input wire logic i_retrain,
    output spm_pkg::spm_dstate_t o_state,
    output logic o_l1_req,
    output logic o_wake_status,
    output logic o_pme_send,
    output logic o_ack_seen
);
    import spm_pkg::*;

    // ****
    // Device power state machine
    // ****
    spm_dstate_t state_d;
    spm_dstate_t state_q;
    wire logic wr_d3 = i_pm_wr && (i_pm_wr_data == `SPM_PS_D3H);
    wire logic wr_d0 = i_pm_wr && (i_pm_wr_data == `SPM_PS_D0);

    // Other encodings ignored; leaving D3hot resets nothing
    always_comb begin
        state_d = state_q;
        case (state_q)
            SPM_D0U: if (i_cfg_done) state_d = SPM_D0A;
            SPM_D0A: if (wr_d3) state_d = SPM_D3H;
            SPM_D3H: begin
                if (i_power_removed) begin
                    state_d = SPM_D3C;
                end else if (wr_d0) begin
                    state_d = SPM_D0U;
                end
            end
            default: state_d = state_q;
        endcase
    end

    // ****
    // Wake event status and retry timer
    // ****
    logic wake_q;
    logic pend_q;
    logic [TW-1:0] rcnt_q;
    wire logic expired = pend_q && (rcnt_q >= i_wake_retry_timeout);
    wire logic can_pme = (state_q != SPM_D3C) && i_pme_allow;
    wire logic wake_d = i_hp_event | (wake_q & ~i_wake_clr);
    wire logic send = can_pme && wake_q && (!pend_q || expired);

    // ****
    // Turn-off acknowledgement timer
    // ****
    logic wait_q;
    logic [TW-1:0] acnt_q;
    wire logic ack_to = wait_q && (acnt_q >= i_turnoff_ack_timeout);
    wire logic ack_ok = wait_q && !i_turnoff_fwd && (i_ack_rx || ack_to);

    // State, link request and wake tracking
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= SPM_D0U;
            o_l1_req <= 1'b0;
            wake_q <= 1'b0;
            pend_q <= 1'b0;
            rcnt_q <= '0;
            o_pme_send <= 1'b0;
        end else begin
            state_q <= state_d;
            o_l1_req <= (state_d == SPM_D3H);
            wake_q <= wake_d;
            pend_q <= send | (pend_q & wake_d);
            o_pme_send <= send;
            if (send) begin
                rcnt_q <= '0;
            end else if (pend_q && i_tick && !expired) begin
                rcnt_q <= rcnt_q + TW'(1);
            end
        end
    end

    // Acknowledge wait per downstream link
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wait_q <= 1'b0;
            acnt_q <= '0;
            o_ack_seen <= 1'b0;
        end else begin
            if (i_turnoff_fwd) begin
                wait_q <= 1'b1;
                acnt_q <= '0;
                o_ack_seen <= 1'b0;
            end else if (ack_ok) begin
                wait_q <= 1'b0;
                o_ack_seen <= 1'b1;
            end else if (i_retrain) begin
                o_ack_seen <= 1'b0;
            end else if (wait_q && i_tick) begin
                acnt_q <= acnt_q + TW'(1);
            end
        end
    end

    assign o_state = state_q;
    assign o_wake_status = wake_q;

    // ****
    // Checks
    // ****
    a_d3_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        wr_d3 && !i_power_removed && state_q == SPM_D0A |=>
        state_q == SPM_D3H) else $error("D3hot not entered");
    a_no_cold_pme: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) o_pme_send |-> $past(state_q) != SPM_D3C)
        else $error("wake message from D3cold");
    a_ack_timeout: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) ack_to && !i_turnoff_fwd |=> o_ack_seen)
        else $error("ack time-out not reported");
    c_pme_resend: cover property (@(posedge i_sys_clk)
        disable iff (i_rst) o_pme_send && expired);

endmodule
`default_nettype wire

/* File: spm_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.svh"

// Behaviour
// - A port's power state affects only that port.
// - A port in D3hot asks for L1 on its own link.
// - Upstream D3hot plus all acks: whole switch low.
// - States D0U, D0A, D3hot, D3cold; reset gives D0U.
// - D3hot write in D0A: D3hot; D0 write in D3hot: D0U.
// - Leaving D3hot resets nothing; context flag set.
// - D3hot: primary-side type 0 config and own messages accepted.
// - D3hot: other requests unsupported.
// - D3hot: receive errors reported; other errors dropped.
// - D3hot: own completions unexpected; others routed.
// - Downstream hot-plug wake messages, never from D3cold.
// - Wake message resent after time-out while status set.
// - Turn-off forwarded on every active downstream port.
// - Ack upstream and L2/L3 Ready only after all acks.
// - Upstream packet cancels aggregation; after ack may drop.
// - Cancelling packet forwarded, retraining link if not L0.
// - Cancel keeps downstream handshake; later packet retrains.
// - Ack time-out counts as ack, link to L2/L3 Ready.
// - Back in D0U after handshake, wake messages resume.
// - Budget capability hidden unless pointed at.
// - Budget header zero, eeprom-loaded; eight data values.
// - Budget data values writable only when unlocked or loaded from eeprom.
module spm_top #(
    parameter int NP = 3,
    parameter int TW = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [NP-1:0] i_cfg_done,
    input wire logic [NP-1:0] i_pm_wr,
    input wire logic [1:0] i_pm_wr_data,
    input wire logic i_power_removed,
    input wire logic [NP-1:0] i_hp_event,
    input wire logic [NP-1:0] i_wake_clr,
    input wire logic [TW-1:0] i_wake_retry_timeout,
    input wire logic [TW-1:0] i_turnoff_ack_timeout,
    input wire spm_pkg::spm_pkt_t i_pkt,
    input wire logic [NP-1:0] i_link_l0,
    input wire logic [NP-1:0] i_evt_err,
    input wire logic i_turnoff_rx,
    input wire logic [NP-1:0] i_ds_active,
    input wire logic [NP-1:0] i_ack_rx,
    input wire logic i_budget_unlock,
    input wire logic i_bd_wr,
    input wire logic i_bd_eeprom,
    input wire logic [`SPM_PB_IDX_W-1:0] i_bd_idx,
    input wire logic [31:0] i_bd_data,
    input wire logic i_hdr_load,
    input wire logic [31:0] i_hdr_data,
    input wire logic [11:0] i_next_capability_pointer,
    output spm_pkg::spm_dstate_t [NP-1:0] o_pm_state,
    output logic [NP-1:0] o_link_l1_req,
    output logic [NP-1:0] o_wake_status,
    output logic [NP-1:0] o_pme_send,
    output logic [NP-1:0] o_ds_l23,
    output logic [NP-1:0] o_turnoff_fwd,
    output logic o_ack_up,
    output logic o_up_l23,
    output logic o_dev_lowpwr,
    output logic o_aggr_cancel,
    output spm_pkg::spm_res_t o_res,
    output logic [NP-1:0] o_retrain,
    output logic [NP-1:0] o_evt_err_msg,
    output logic o_context_kept_flag,
    output logic [31:0] o_budget_header,
    output logic o_budget_visible,
    output logic [31:0] o_bd_rd
);
    import spm_pkg::*;

    // ****
    // Common enables
    // ****
    localparam logic [NP-1:0] DS_MASK = ~NP'(1);
    localparam logic [`SPM_TICK_W-1:0] TICK_LAST =
        `SPM_TICK_W'(`SPM_TICK_CYC - 1);

    logic [`SPM_TICK_W-1:0] tick_cnt_q;
    logic tick_q;

    // Microsecond enable pulse for the port timers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            if (tick_cnt_q == TICK_LAST) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + `SPM_TICK_W'(1);
            end
        end
    end

    // ****
    // Per-port power management
    // ****
    spm_agg_t agg_q;
    spm_agg_t agg_d;
    logic [NP-1:0] ack_seen;
    logic [NP-1:0] fwd_q;
    logic [NP-1:0] retrain_q;
    wire logic pme_allow = (agg_q != SPM_AG_DONE);

    // Ports are independent of each other
    for (genvar p = 0; p < NP; p++) begin : g_port
        spm_port #(
            .TW(TW)
        ) u_port (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_tick(tick_q),
            .i_cfg_done(i_cfg_done[p]),
            .i_pm_wr(i_pm_wr[p]),
            .i_pm_wr_data(i_pm_wr_data),
            .i_power_removed(i_power_removed),
            .i_hp_event(i_hp_event[p] & DS_MASK[p]),
            .i_wake_clr(i_wake_clr[p]),
            .i_pme_allow(pme_allow),
            .i_wake_retry_timeout(i_wake_retry_timeout),
            .i_turnoff_ack_timeout(i_turnoff_ack_timeout),
            .i_turnoff_fwd(fwd_q[p]),
            .i_ack_rx(i_ack_rx[p]),
            .i_retrain(retrain_q[p]),
            .o_state(o_pm_state[p]),
            .o_l1_req(o_link_l1_req[p]),
            .o_wake_status(o_wake_status[p]),
            .o_pme_send(o_pme_send[p]),
            .o_ack_seen(ack_seen[p])
        );
    end

    assign o_ds_l23 = ack_seen;
    assign o_turnoff_fwd = fwd_q;
    assign o_retrain = retrain_q;

    // ****
    // Turn-off acknowledgement aggregation
    // ****
    logic [NP-1:0] act_q;
    wire logic up_pkt = i_pkt.vld && !i_pkt.sec && (i_pkt.src == 2'h0);
    wire logic all_acked = &(ack_seen | ~act_q);
    wire logic cancel = (agg_q == SPM_AG_WAIT) && up_pkt;
    wire logic start = i_turnoff_rx && (agg_q != SPM_AG_WAIT);
    wire logic up_d0 = i_pm_wr[0] && (i_pm_wr_data == `SPM_PS_D0);
    wire logic send_ack = (agg_q == SPM_AG_WAIT) && !cancel && all_acked;

    // Cancel beats a completing aggregation in the same cycle
    always_comb begin
        agg_d = agg_q;
        case (agg_q)
            SPM_AG_IDLE: if (start) agg_d = SPM_AG_WAIT;
            SPM_AG_WAIT: begin
                if (cancel) begin
                    agg_d = SPM_AG_IDLE;
                end else if (all_acked) begin
                    agg_d = SPM_AG_DONE;
                end
            end
            SPM_AG_DONE: begin
                if (up_d0) begin
                    agg_d = SPM_AG_IDLE;
                end else if (start) begin
                    agg_d = SPM_AG_WAIT;
                end
            end
            default: agg_d = SPM_AG_IDLE;
        endcase
    end

    // Aggregation state and upstream link outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            agg_q <= SPM_AG_IDLE;
            act_q <= '0;
            fwd_q <= '0;
            o_ack_up <= 1'b0;
            o_up_l23 <= 1'b0;
            o_dev_lowpwr <= 1'b0;
            o_aggr_cancel <= 1'b0;
        end else begin
            agg_q <= agg_d;
            fwd_q <= start ? (i_ds_active & DS_MASK) : '0;
            if (start) begin
                act_q <= i_ds_active & DS_MASK;
            end
            o_ack_up <= send_ack;
            o_up_l23 <= (agg_d == SPM_AG_DONE);
            o_dev_lowpwr <= (agg_d == SPM_AG_DONE) &&
                (o_pm_state[0] == SPM_D3H) && !up_d0;
            o_aggr_cancel <= cancel;
        end
    end

    // ****
    // Packet disposition
    // ****
    wire spm_dstate_t st_src = o_pm_state[i_pkt.src];
    wire logic src_d3 = (st_src == SPM_D3H);
    wire logic to_self = (i_pkt.kind == SPM_K_CFG0) ||
        (i_pkt.kind == SPM_K_MSG_SELF) || (i_pkt.kind == SPM_K_CPL_SELF);
    wire logic dst_down = (i_pkt.dst != 2'h0);
    wire logic dst_l0 = i_link_l0[i_pkt.dst];

    spm_disp_t base;
    spm_disp_t disp;

    // Handling by power state of the receiving bridge
    always_comb begin
        base = to_self ? SPM_R_ACCEPT : SPM_R_FWD;
        if (src_d3) begin
            case (i_pkt.kind)
                SPM_K_CPL_THRU: base = SPM_R_FWD;
                SPM_K_CPL_SELF: base = SPM_R_UC;
                SPM_K_CFG0, SPM_K_MSG_SELF:
                    base = i_pkt.sec ? SPM_R_UR : SPM_R_ACCEPT;
                default: base = SPM_R_UR;
            endcase
        end
    end

    // Drops after the ack and retrain holds toward sleeping links
    always_comb begin
        disp = base;
        if (!i_pkt.vld) begin
            disp = SPM_R_NONE;
        end else if ((agg_q == SPM_AG_DONE) && up_pkt) begin
            disp = SPM_R_DROP;
        end else if ((base == SPM_R_FWD) && dst_down && !dst_l0) begin
            disp = SPM_R_HOLD;
        end
    end

    wire logic need_retrain = i_pkt.vld && (disp == SPM_R_HOLD);

    // Registered answer and error reporting
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_res <= '0;
            retrain_q <= '0;
            o_evt_err_msg <= '0;
        end else begin
            o_res.vld <= i_pkt.vld;
            o_res.disp <= disp;
            o_res.err_msg <= i_pkt.vld && i_pkt.rx_err;
            retrain_q <= need_retrain ?
                (NP'(1) << i_pkt.dst) : '0;
            for (int p = 0; p < NP; p++) begin
                o_evt_err_msg[p] <= i_evt_err[p] &&
                    (o_pm_state[p] != SPM_D3H);
            end
        end
    end

    // ****
    // Power budgeting capability
    // ****
    logic [31:0] dv_q [`SPM_PB_DV_NUM];
    wire logic bd_wr_ok = i_bd_wr && (i_budget_unlock || i_bd_eeprom);

    // Header, visibility and constant context flag
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_budget_header <= `SPM_PB_HDR_RST;
            o_budget_visible <= 1'b0;
            o_context_kept_flag <= `SPM_CTX_KEPT_RST;
            o_bd_rd <= '0;
        end else begin
            if (i_hdr_load) begin
                o_budget_header <= i_hdr_data;
            end
            o_budget_visible <=
                (i_next_capability_pointer == `SPM_PB_CAP_OFS);
            o_bd_rd <= dv_q[i_bd_idx];
        end
    end

    // Data values, locked unless unlocked or loaded from eeprom
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int i = 0; i < `SPM_PB_DV_NUM; i++) begin
                dv_q[i] <= `SPM_PB_DV_RST;
            end
        end else if (bd_wr_ok) begin
            dv_q[i_bd_idx] <= i_bd_data;
        end
    end

    // ****
    // Checks
    // ****
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_cancel_aggr: assert property (
        cancel |=> agg_q == SPM_AG_IDLE && o_aggr_cancel && !o_ack_up)
        else $error("aggregation not cancelled");
    a_ack_needs_all: assert property (
        o_ack_up |-> $past(agg_q) == SPM_AG_WAIT && $past(all_acked)
        && o_up_l23) else $error("ack sent before all acks");
    a_turnoff_fwd: assert property (
        start |=> o_turnoff_fwd == ($past(i_ds_active) & DS_MASK))
        else $error("turn-off not forwarded");
    a_d3_sec_ur: assert property (
        i_pkt.vld && i_pkt.sec && src_d3 && i_pkt.kind == SPM_K_REQ
        |=> o_res.disp == SPM_R_UR) else $error("secondary not UR");
    a_d3_cfg_ok: assert property (
        i_pkt.vld && !i_pkt.sec && src_d3 && i_pkt.kind == SPM_K_CFG0
        && agg_q != SPM_AG_DONE |=> o_res.disp == SPM_R_ACCEPT)
        else $error("config refused in D3hot");
    a_d3_cpl_uc: assert property (
        i_pkt.vld && src_d3 && i_pkt.kind == SPM_K_CPL_SELF
        && !(agg_q == SPM_AG_DONE && up_pkt) |=> o_res.disp == SPM_R_UC)
        else $error("own completion not unexpected");
    a_evt_err_drop: assert property (
        i_evt_err[1] && o_pm_state[1] == SPM_D3H |=> !o_evt_err_msg[1])
        else $error("event error sent in D3hot");
    a_budget_lock: assert property (
        i_bd_wr && !bd_wr_ok && i_bd_idx == 3'h0 |=> $stable(dv_q[0]))
        else $error("locked data value written");
    a_low_power: assert property (
        o_dev_lowpwr |-> o_up_l23 && $past(o_pm_state[0]) == SPM_D3H)
        else $error("low power without handshake");
    a_hold_retrain: assert property (
        need_retrain |=> o_res.disp == SPM_R_HOLD && o_retrain != '0)
        else $error("no retrain for held packet");

    c_cancel: cover property (cancel);
    c_ack_up: cover property (o_ack_up ##1 o_dev_lowpwr);
    c_hold: cover property (need_retrain && cancel);
    c_resume: cover property (agg_q == SPM_AG_DONE ##1
        agg_q == SPM_AG_IDLE ##[1:50] |o_pme_send);

endmodule
`default_nettype wire

/* File: spm_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module spm_partner #(
    parameter int NP = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [NP-1:0] i_fwd,
    input wire logic [NP-1:0] i_slow,
    input wire logic [NP-1:0] i_mute,
    input wire logic [NP-1:0] i_retrain,
    output logic [NP-1:0] o_ack,
    output logic [NP-1:0] o_l0
);
    logic [3:0] cnt_q [NP];
    // Ack 1 or 9 cycles after turn-off, never when muted; link leaves L0
    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < NP; p++) begin
            o_ack[p] <= 1'h0;
            if (i_rst) begin
                cnt_q[p] <= 4'h0;
                o_l0[p] <= 1'h1;
            end else if (i_fwd[p] && !i_mute[p]) begin
                cnt_q[p] <= i_slow[p] ? 4'h9 : 4'h1;
            end else if (cnt_q[p] == 4'h1) begin
                cnt_q[p] <= 4'h0;
                o_ack[p] <= 1'h1;
                o_l0[p] <= 1'h0;
            end else if (cnt_q[p] != 4'h0) begin
                cnt_q[p] <= cnt_q[p] - 4'h1;
            end else if (i_retrain[p]) begin
                o_l0[p] <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: switch_port_power_management_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.svh"
module switch_port_power_management_tb;
    import spm_pkg::*;
    localparam int NP = 3;
    logic i_sys_clk = 1'h0;
    logic i_rst = 1'h1;
    logic [NP-1:0] i_cfg_done = '0, i_pm_wr = '0, i_hp_event = '0;
    logic [NP-1:0] i_wake_clr = '0, i_evt_err = '0, i_ds_active = '0;
    logic [NP-1:0] i_link_l0, i_ack_rx, slow = '0, mute = '0;
    logic [1:0] i_pm_wr_data = 2'h0;
    logic i_power_removed = 1'h0, i_turnoff_rx = 1'h0, i_hdr_load = 1'h0;
    logic i_budget_unlock = 1'h0, i_bd_wr = 1'h0, i_bd_eeprom = 1'h0;
    logic [2:0] i_bd_idx = 3'h0;
    logic [31:0] i_bd_data = 32'h0, i_hdr_data = 32'h0;
    logic [11:0] i_next_capability_pointer = 12'h0;
    spm_pkt_t i_pkt = '0;
    spm_dstate_t [NP-1:0] o_pm_state;
    logic [NP-1:0] o_link_l1_req, o_wake_status, o_pme_send, o_ds_l23;
    logic [NP-1:0] o_turnoff_fwd, o_retrain, o_evt_err_msg;
    logic o_ack_up, o_up_l23, o_dev_lowpwr, o_aggr_cancel;
    logic o_context_kept_flag, o_budget_visible;
    logic [31:0] o_budget_header, o_bd_rd;
    spm_res_t o_res;
    int n_mismatch = 0;
    int check_count = 0;
    int k, c;
    // ****
    // Block, partners and helpers
    // ****
    spm_top #(.NP(NP), .TW(16)) uut (.i_sys_clk, .i_rst, .i_cfg_done,
        .i_pm_wr, .i_pm_wr_data, .i_power_removed, .i_hp_event, .i_wake_clr,
        .i_wake_retry_timeout(16'h0001), .i_turnoff_ack_timeout(16'h0001),
        .i_pkt, .i_link_l0, .i_evt_err, .i_turnoff_rx, .i_ds_active,
        .i_ack_rx, .i_budget_unlock, .i_bd_wr, .i_bd_eeprom, .i_bd_idx,
        .i_bd_data, .i_hdr_load, .i_hdr_data, .i_next_capability_pointer,
        .o_pm_state, .o_link_l1_req, .o_wake_status, .o_pme_send, .o_ds_l23,
        .o_turnoff_fwd, .o_ack_up, .o_up_l23, .o_dev_lowpwr, .o_aggr_cancel,
        .o_res, .o_retrain, .o_evt_err_msg, .o_context_kept_flag,
        .o_budget_header, .o_budget_visible, .o_bd_rd);
    spm_partner #(.NP(NP)) peer (.i_sys_clk, .i_rst, .i_fwd(o_turnoff_fwd),
        .i_slow(slow), .i_mute(mute), .i_retrain(o_retrain),
        .o_ack(i_ack_rx), .o_l0(i_link_l0));
    // Clock of 10 ns
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic do_rst;
        @(posedge i_sys_clk);
        i_rst <= 1'h1;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        tick(1);
    endtask
    task automatic pmw(input logic [NP-1:0] m, input logic [1:0] d);
        @(posedge i_sys_clk);
        i_pm_wr <= m;
        i_pm_wr_data <= d;
        @(posedge i_sys_clk);
        i_pm_wr <= '0;
        #1;
    endtask
    task automatic to_d3h(input logic [NP-1:0] m);
        @(posedge i_sys_clk);
        i_cfg_done <= m;
        @(posedge i_sys_clk);
        i_cfg_done <= '0;
        pmw(m, `SPM_PS_D3H);
    endtask
    task automatic hp(input logic [NP-1:0] m);
        @(posedge i_sys_clk);
        i_hp_event <= m;
        @(posedge i_sys_clk);
        i_hp_event <= '0;
        #1;
    endtask
    task automatic turnoff;
        @(posedge i_sys_clk);
        i_turnoff_rx <= 1'h1;
        @(posedge i_sys_clk);
        i_turnoff_rx <= 1'h0;
        #1;
    endtask
    // One packet and its answer
    task automatic pkt(input logic s, input spm_kind_t kd,
                       input logic [1:0] sr, input logic [1:0] ds,
                       input logic er, input spm_disp_t e);
        @(posedge i_sys_clk);
        i_pkt <= '{1'h1, s, kd, sr, ds, er};
        @(posedge i_sys_clk);
        i_pkt <= '0;
        #1;
        chk("disp", e, o_res.disp);
        chk("err_msg", er, o_res.err_msg);
    endtask
    task automatic bdw(input logic [2:0] x, input logic [31:0] d,
                       input logic u, input logic ee);
        @(posedge i_sys_clk);
        i_budget_unlock <= u;
        i_bd_eeprom <= ee;
        i_bd_idx <= x;
        i_bd_data <= d;
        i_bd_wr <= 1'h1;
        @(posedge i_sys_clk);
        i_bd_wr <= 1'h0;
        tick(2);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_states;
        do_rst;
        chk("rst_state", SPM_D0U, o_pm_state[1]);
        chk("ctx", 1, o_context_kept_flag);
        @(posedge i_sys_clk);
        i_cfg_done <= 3'h6;
        @(posedge i_sys_clk);
        i_cfg_done <= 3'h0;
        #1;
        chk("d0a", SPM_D0A, o_pm_state[1]);
        pmw(3'h2, 2'h1);
        chk("bad_enc", SPM_D0A, o_pm_state[1]);
        pmw(3'h2, `SPM_PS_D3H);
        chk("d3h", SPM_D3H, o_pm_state[1]);
        chk("l1_req", 3'h2, o_link_l1_req);
        chk("other", SPM_D0A, o_pm_state[2]);
        pmw(3'h2, `SPM_PS_D0);
        chk("d0u", SPM_D0U, o_pm_state[1]);
        chk("ctx_kept", 1, o_context_kept_flag);
    endtask
    task automatic t_pkts;
        do_rst;
        to_d3h(3'h2);
        pkt(1'h0, SPM_K_CFG0, 2'h1, 2'h1, 1'h0, SPM_R_ACCEPT);
        pkt(1'h0, SPM_K_MSG_SELF, 2'h1, 2'h1, 1'h1, SPM_R_ACCEPT);
        pkt(1'h1, SPM_K_CFG0, 2'h1, 2'h1, 1'h0, SPM_R_UR);
        pkt(1'h0, SPM_K_REQ, 2'h1, 2'h1, 1'h1, SPM_R_UR);
        pkt(1'h0, SPM_K_CPL_SELF, 2'h1, 2'h1, 1'h0, SPM_R_UC);
        pkt(1'h0, SPM_K_CPL_THRU, 2'h1, 2'h2, 1'h0, SPM_R_FWD);
        pkt(1'h1, SPM_K_REQ, 2'h2, 2'h1, 1'h0, SPM_R_FWD);
        @(posedge i_sys_clk);
        i_evt_err <= 3'h6;
        @(posedge i_sys_clk);
        i_evt_err <= 3'h0;
        #1;
        chk("evt_err", 3'h4, o_evt_err_msg);
    endtask
    task automatic t_wake;
        do_rst;
        to_d3h(3'h2);
        hp(3'h2);
        chk("wake_st", 3'h2, o_wake_status);
        tick(1);
        chk("pme", 3'h2, o_pme_send);
        tick(1);
        for (k = 0; k < 400 && o_pme_send[1] !== 1'h1; k++) tick(1);
        chk("retry", 1, o_pme_send[1]);
        @(posedge i_sys_clk);
        i_wake_clr <= 3'h2;
        i_power_removed <= 1'h1;
        @(posedge i_sys_clk);
        i_wake_clr <= 3'h0;
        hp(3'h2);
        chk("d3c", SPM_D3C, o_pm_state[1]);
        c = 0;
        repeat (300) begin
            tick(1);
            c += o_pme_send[1];
        end
        chk("no_pme", 0, c);
        i_power_removed <= 1'h0;
    endtask
    task automatic t_fence;
        do_rst;
        i_ds_active <= 3'h6;
        slow <= 3'h4;
        mute <= 3'h0;
        to_d3h(3'h1);
        turnoff;
        chk("fwd", 3'h6, o_turnoff_fwd);
        tick(3);
        chk("ds_part", 3'h2, o_ds_l23);
        chk("no_ack", 0, o_ack_up);
        for (k = 0; k < 50 && o_ack_up !== 1'h1; k++) tick(1);
        chk("ds_all", 3'h6, o_ds_l23);
        tick(1);
        chk("up_l23", 1, o_up_l23);
        chk("lowpwr", 1, o_dev_lowpwr);
        pkt(1'h0, SPM_K_REQ, 2'h0, 2'h1, 1'h0, SPM_R_DROP);
        pmw(3'h1, `SPM_PS_D0);
        hp(3'h2);
        for (k = 0; k < 150 && o_pme_send[1] !== 1'h1; k++) tick(1);
        chk("pme_resume", 1, o_pme_send[1]);
    endtask
    task automatic t_cancel;
        do_rst;
        i_ds_active <= 3'h6;
        slow <= 3'h0;
        mute <= 3'h4;
        turnoff;
        tick(3);
        pkt(1'h0, SPM_K_REQ, 2'h0, 2'h1, 1'h0, SPM_R_HOLD);
        chk("cancel", 1, o_aggr_cancel);
        chk("retrain", 3'h2, o_retrain);
        c = 0;
        for (k = 0; k < 400 && o_ds_l23[2] !== 1'h1; k++) begin
            tick(1);
            c += o_ack_up;
        end
        chk("timeout", 1, o_ds_l23[2]);
        chk("no_ack_up", 0, c);
        pkt(1'h0, SPM_K_REQ, 2'h0, 2'h1, 1'h0, SPM_R_FWD);
    endtask
    task automatic t_budget;
        do_rst;
        chk("hdr_rst", `SPM_PB_HDR_RST, o_budget_header);
        chk("hidden", 0, o_budget_visible);
        @(posedge i_sys_clk);
        i_next_capability_pointer <= `SPM_PB_CAP_OFS;
        tick(1);
        chk("visible", 1, o_budget_visible);
        bdw(3'h5, 32'h1234_5678, 1'h0, 1'h0);
        chk("locked", `SPM_PB_DV_RST, o_bd_rd);
        for (int j = 0; j < 8; j++) begin
            bdw(3'(j), 32'hA500 + 32'(j), 1'h1, 1'h0);
            chk("unlocked", 32'hA500 + 32'(j), o_bd_rd);
        end
        bdw(3'h3, 32'h0, 1'h0, 1'h0);
        chk("kept", 32'hA503, o_bd_rd);
        bdw(3'h3, 32'h00C0_FFEE, 1'h0, 1'h1);
        chk("eeprom", 32'h00C0_FFEE, o_bd_rd);
        @(posedge i_sys_clk);
        i_hdr_data <= 32'h0011_0004;
        i_hdr_load <= 1'h1;
        @(posedge i_sys_clk);
        i_hdr_load <= 1'h0;
        #1;
        chk("hdr_load", 32'h0011_0004, o_budget_header);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        t_states;
        t_pkts;
        t_wake;
        t_fence;
        t_cancel;
        t_budget;
        test_done;
    end
    // Watchdog, far past the longest run
    initial begin
        #300000;
        n_mismatch++;
        test_done;
    end
endmodule
`default_nettype wire
